/* File: rtl/bps_sequencer.sv */
// Function
// - Starts by itself at power-up; supply-good input watched every cycle.
// - Pump runs on free clock below power-good, then on PWM clock.
// - Soft-start begins only once the bias rail is reported good.
// - During soft-start the duty limit follows a rising ramp.
// - Full ramp lasts about 6.5 ms at a switching frequency near 315 kHz.
// - Never both gates on; each turns on only after other senses off.
// - Enable input low longer than 40 us disables the device.
// - High enable input leaves disabled state at once, unfiltered.
// - Entering disabled state switches the charge pump off.
// - Low pulses shorter than 22 us are treated as sync pulses.
// - Sync at 1.1 to 2.0 times free frequency is locked to.
// - Frequency lock reached within about 200 sync cycles.
// - Overcurrent trip starts a new soft-start in hiccup fashion.
// - Overcurrent stops switching at once and runs internal ramps.
// - Output stays off three ramps; the fourth ramp drives the output.
// - Repeated overcurrent repeats the hiccup delay without limit.
// - Soft-start ramp counts 2048 switching periods.
// - Duty cycle limited to about 96 percent of each period.
// - Disabled state stops gates and sequencing entirely.
//
// Purpose: Sequencing, PWM timing and gate interlock of a buck controller.
// Assumes: Gate-off sense inputs come from 0.8 V comparators.
// Notes: Duty demand stands for the error amplifier against the sawtooth.
`timescale 1ns/1ps

module bps_sequencer
    import bps_pkg::*;
#(
    parameter int DISABLE_COUNT = DISABLE_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_clock_en,
    input wire logic i_bias_good,
    input wire logic i_sync_en,
    input wire logic i_overcurrent,
    input wire logic i_high_gate_off,
    input wire logic i_low_gate_off,
    input wire logic [7:0] i_duty_demand,
    output logic o_high_side_gate_drive,
    output logic o_low_side_gate_drive,
    output logic o_pump_enable,
    output logic o_pump_on_pwm,
    output logic o_sync_locked,
    output logic o_disabled,
    output logic o_hiccup,
    output logic [10:0] o_soft_start_ramp
);

    localparam logic [15:0] DISABLE_LAST = 16'(DISABLE_COUNT - 1);
    localparam logic [15:0] SYNC_MAX = 16'(SYNC_MAX_CYCLES);

    function automatic logic [7:0] min8(input logic [7:0] a,
                                        input logic [7:0] b);
        min8 = (a < b) ? a : b;
    endfunction

    bps_regs_t s;
    bps_regs_t next_s;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer, oscillator and gate logic

    logic period_end;
    logic sync_edge;
    logic sync_ok;
    logic ramp_done;
    logic want_high;
    logic switching;
    logic [7:0] duty;
    logic [7:0] next_phase;

    always_comb begin
        next_s = s;
        // A sync pulse ends on the rising edge after a short low time
        sync_edge = i_sync_en && !s.sync_prev && s.sync_seen;
        sync_ok = sync_edge && (s.meas_cnt >= SYNC_PERIOD_MIN) &&
                  (s.meas_cnt <= SYNC_PERIOD_MAX);
        period_end = 1'b0;
        ramp_done = 1'b0;
        next_s.sync_prev = i_sync_en;

        // Enable filter: only a long low disables, a high wakes at once
        if (i_sync_en) begin
            next_s.low_cnt = 16'h0000;
        end else if (s.low_cnt != 16'hffff) begin
            next_s.low_cnt = s.low_cnt + 16'h0001;
        end
        if (!i_sync_en && s.low_cnt < SYNC_MAX) begin
            next_s.sync_seen = 1'b1;
        end else if (!i_sync_en) begin
            next_s.sync_seen = 1'b0;
        end else if (sync_edge) begin
            next_s.sync_seen = 1'b0;
        end

        // Period measurement between sync pulses
        if (sync_edge) begin
            next_s.meas_cnt = 16'h0001;
        end else if (s.meas_cnt != 16'hffff) begin
            next_s.meas_cnt = s.meas_cnt + 16'h0001;
        end
        // Lock needs an unbroken run of in-window pulses
        if (sync_ok) begin
            next_s.slot_div = s.meas_cnt[15:8];
            if (s.lock_cnt != LOCK_PULSES) begin
                next_s.lock_cnt = s.lock_cnt + 8'h01;
            end
        end else if (sync_edge || s.meas_cnt > FREE_PERIOD) begin
            next_s.lock_cnt = 8'h00;
            next_s.slot_div = FREE_SLOT_DIV;
        end
        next_s.locked = (next_s.lock_cnt == LOCK_PULSES);

        // Slot divider and 256-slot phase; a locked sync realigns phase
        next_phase = s.phase;
        if (s.locked && sync_ok) begin
            next_s.div_cnt = 8'h00;
            next_phase = 8'h00;
        end else if (s.div_cnt + 8'h01 >= s.slot_div) begin
            next_s.div_cnt = 8'h00;
            next_phase = s.phase + 8'h01;
            period_end = (s.phase == LAST_SLOT);
        end else begin
            next_s.div_cnt = s.div_cnt + 8'h01;
        end
        next_s.phase = next_phase;

        // Ramp counts switching periods, so its length tracks frequency
        if ((s.state == ST_SOFT || s.state == ST_HICCUP) && period_end) begin
            next_s.ss_cnt = s.ss_cnt + 11'h001;
            ramp_done = (s.ss_cnt == SS_LAST);
        end

        unique case (s.state)
            ST_POR: begin
                next_s.ss_cnt = 11'h000;
                if (i_bias_good) begin
                    next_s.state = ST_SOFT;
                end
            end
            ST_SOFT: begin
                if (ramp_done) begin
                    next_s.state = ST_RUN;
                end
            end
            ST_RUN: begin
                next_s.ss_cnt = SS_LAST;
            end
            ST_HICCUP: begin
                if (ramp_done) begin
                    next_s.hic_cnt = s.hic_cnt + 2'h1;
                    if (s.hic_cnt == HICCUP_RAMPS - 2'h1) begin
                        next_s.hic_cnt = 2'h0;
                        next_s.state = ST_SOFT;
                    end
                end
            end
            ST_OFF: begin
                next_s.ss_cnt = 11'h000;
                next_s.hic_cnt = 2'h0;
                if (i_sync_en) begin
                    next_s.state = ST_POR;
                end
            end
        endcase

        // Overcurrent restarts ramps from zero, again on every trip
        if ((s.state == ST_SOFT || s.state == ST_RUN) && i_overcurrent) begin
            next_s.state = ST_HICCUP;
            next_s.ss_cnt = 11'h000;
            next_s.hic_cnt = 2'h0;
        end
        // Losing the bias rail drops back to waiting for power-good
        if (!i_bias_good && s.state != ST_OFF) begin
            next_s.state = ST_POR;
            next_s.ss_cnt = 11'h000;
        end
        if (!i_sync_en && s.low_cnt >= DISABLE_LAST) begin
            next_s.state = ST_OFF;
        end

        // Duty limit: demand, clamped by the ramp and the maximum
        duty = min8(i_duty_demand, MAX_DUTY);
        if (next_s.state == ST_SOFT) begin
            duty = min8(duty, next_s.ss_cnt[10:3]);
        end
        switching = (next_s.state == ST_SOFT || next_s.state == ST_RUN);
        want_high = switching && (next_phase < duty);

        // Each gate waits for the other one to be sensed off
        next_s.hs = want_high && i_low_gate_off && !s.ls;
        next_s.ls = switching && !want_high && i_high_gate_off &&
                    !s.hs && !next_s.hs;

        next_s.pump_en = (next_s.state != ST_OFF);
        next_s.pump_on_pwm = next_s.pump_en &&
                             (next_s.state != ST_POR);
        next_s.off = (next_s.state == ST_OFF);
        next_s.hic = (next_s.state == ST_HICCUP);
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            s <= '0;
            s.state <= ST_POR;
            s.slot_div <= FREE_SLOT_DIV;
            s.sync_prev <= 1'b1;
            s.pump_en <= 1'b1;
        end else if (i_clock_en) begin
            s <= next_s;
        end
    end

    assign o_high_side_gate_drive = s.hs;
    assign o_low_side_gate_drive = s.ls;
    assign o_pump_enable = s.pump_en;
    assign o_pump_on_pwm = s.pump_on_pwm;
    assign o_sync_locked = s.locked;
    assign o_disabled = s.off;
    assign o_hiccup = s.hic;
    assign o_soft_start_ramp = s.ss_cnt;

    ////////////////////////////////////////////////////////////////////////
    // Assertions; they assume the clock enable is high

    sequence s_trip;
        i_clock_en && i_overcurrent && i_bias_good && i_sync_en &&
        (s.state == ST_SOFT || s.state == ST_RUN);
    endsequence

    sequence s_shut;
        (s.state == ST_HICCUP) && !s.hs && !s.ls && (s.ss_cnt == 11'h000);
    endsequence

    property p_no_overlap;
        @(posedge i_clock) disable iff (i_srst) !(s.hs && s.ls);
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("both gates driven");

    property p_high_waits;
        @(posedge i_clock) disable iff (i_srst)
            $rose(s.hs) |-> $past(i_low_gate_off) && !$past(s.ls);
    endproperty
    a_high_waits: assert property (p_high_waits)
        else $error("high gate on before low gate off");

    property p_oc_stop;
        @(posedge i_clock) disable iff (i_srst) s_trip |=> s_shut;
    endproperty
    a_oc_stop: assert property (p_oc_stop)
        else $error("overcurrent did not stop switching");

    property p_quiet_gates;
        @(posedge i_clock) disable iff (i_srst)
            (s.state == ST_HICCUP || s.state == ST_OFF) |-> !s.hs && !s.ls;
    endproperty
    a_quiet_gates: assert property (p_quiet_gates)
        else $error("gate driven while idle");

    property p_fourth_ramp;
        @(posedge i_clock) disable iff (i_srst)
            i_clock_en && i_bias_good && i_sync_en && !i_overcurrent &&
            s.state == ST_HICCUP && s.hic_cnt == 2'h2 &&
            s.ss_cnt == SS_LAST && period_end
            |=> s.state == ST_SOFT && s.ss_cnt == 11'h000;
    endproperty
    a_fourth_ramp: assert property (p_fourth_ramp)
        else $error("hiccup delay not three ramps");

    property p_max_duty;
        @(posedge i_clock) disable iff (i_srst)
            s.phase >= MAX_DUTY |-> !s.hs;
    endproperty
    a_max_duty: assert property (p_max_duty)
        else $error("duty beyond maximum");

    property p_disable;
        @(posedge i_clock) disable iff (i_srst)
            i_clock_en && !i_sync_en && s.low_cnt == DISABLE_LAST
            |=> s.state == ST_OFF ##0 !s.pump_en ##0 !s.hs;
    endproperty
    a_disable: assert property (p_disable)
        else $error("long low did not disable");

    property p_wake;
        @(posedge i_clock) disable iff (i_srst)
            i_clock_en && s.state == ST_OFF && i_sync_en
            |=> s.state != ST_OFF && s.ss_cnt == 11'h000 && s.pump_en;
    endproperty
    a_wake: assert property (p_wake)
        else $error("enable high did not wake");

    property p_pump_clock;
        @(posedge i_clock) disable iff (i_srst)
            s.pump_on_pwm |-> s.state != ST_POR && s.state != ST_OFF;
    endproperty
    a_pump_clock: assert property (p_pump_clock)
        else $error("pump on PWM clock before power-good");

    property p_ramp_limit;
        @(posedge i_clock) disable iff (i_srst)
            s.state == ST_SOFT && s.hs |-> s.phase < s.ss_cnt[10:3];
    endproperty
    a_ramp_limit: assert property (p_ramp_limit)
        else $error("pulse wider than soft-start ramp");

    property p_start_gate;
        @(posedge i_clock) disable iff (i_srst)
            s.state == ST_POR |-> !s.hs && !s.ls && s.ss_cnt == 11'h000;
    endproperty
    a_start_gate: assert property (p_start_gate)
        else $error("switching before power-good");

    property p_pump_off;
        @(posedge i_clock) disable iff (i_srst)
            s.state == ST_OFF |-> !s.pump_en && !s.pump_on_pwm;
    endproperty
    a_pump_off: assert property (p_pump_off)
        else $error("pump running while disabled");

    property p_low_waits;
        @(posedge i_clock) disable iff (i_srst)
            $rose(s.ls) |-> $past(i_high_gate_off) && !$past(s.hs);
    endproperty
    a_low_waits: assert property (p_low_waits)
        else $error("low gate on before high gate off");

    // A lost rail must not leave a stale ramp behind for the next start
    property p_bias_loss;
        @(posedge i_clock) disable iff (i_srst)
            i_clock_en && !i_bias_good && s.state != ST_OFF &&
            (i_sync_en || s.low_cnt < DISABLE_LAST)
            |=> s.state == ST_POR && s.ss_cnt == 11'h000;
    endproperty
    a_bias_loss: assert property (p_bias_loss)
        else $error("bias loss did not restart");

endmodule

/* File: rtl/bps_pkg.sv */
// Purpose: Shared constants and types for the buck PWM sequencer.
// Assumes: 125 MHz system clock, all inputs synchronous to it.
// Notes: Switching period is built from 256 phase slots.
package bps_pkg;

    localparam int CLOCK_PERIOD_NS = 8;
    // Enable filter and sync pulse timing
    localparam int DISABLE_TIME_NS = 40000;
    localparam int DISABLE_CYCLES = DISABLE_TIME_NS / CLOCK_PERIOD_NS;
    localparam int SYNC_MAX_NS = 22000;
    localparam int SYNC_MAX_CYCLES = SYNC_MAX_NS / CLOCK_PERIOD_NS;
    localparam int SYNC_MIN_NS = 40;
    localparam int SYNC_MIN_CYCLES =
        (SYNC_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    // Free-running oscillator, nominal 100 kHz
    localparam int FREE_PERIOD_NS = 10000;
    localparam int FREE_PERIOD_CYCLES = FREE_PERIOD_NS / CLOCK_PERIOD_NS;
    localparam logic [15:0] FREE_PERIOD = 16'(FREE_PERIOD_CYCLES);
    localparam logic [7:0] FREE_SLOT_DIV = 8'(FREE_PERIOD_CYCLES / 256);
    // Sync window: 1.1x to 2.0x the free-running frequency
    localparam logic [15:0] SYNC_PERIOD_MIN = 16'(FREE_PERIOD_CYCLES / 2);
    localparam logic [15:0] SYNC_PERIOD_MAX =
        16'(FREE_PERIOD_CYCLES * 10 / 11);
    localparam logic [7:0] LOCK_PULSES = 8'd200;
    // Soft-start: 2048 switching periods, about 6.5 ms near 315 kHz
    localparam int SOFT_START_TIME_US = 6500;
    localparam logic [10:0] SS_LAST = 11'h7ff;
    localparam logic [1:0] HICCUP_RAMPS = 2'h3;
    // 96 percent of 256 slots
    localparam logic [7:0] MAX_DUTY = 8'hf5;
    localparam logic [7:0] LAST_SLOT = 8'hff;

    typedef enum logic [2:0] {
        ST_POR = 3'b000,
        ST_SOFT = 3'b001,
        ST_RUN = 3'b010,
        ST_HICCUP = 3'b011,
        ST_OFF = 3'b100
    } bps_state_t;

    typedef struct packed {
        bps_state_t state;
        logic [15:0] low_cnt;
        logic [15:0] meas_cnt;
        logic sync_seen;
        logic sync_prev;
        logic [7:0] slot_div;
        logic [7:0] div_cnt;
        logic [7:0] phase;
        logic [10:0] ss_cnt;
        logic [1:0] hic_cnt;
        logic [7:0] lock_cnt;
        logic locked;
        logic hs;
        logic ls;
        logic pump_en;
        logic pump_on_pwm;
        logic off;
        logic hic;
    } bps_regs_t;

endpackage

/* File: tb/bps_fet_model.sv */
// Purpose: External FET pair and combined sync/enable source.
// Assumes: Gate-off sense follows the drive after a settle delay.
// Notes: Sync pulses run only while i_sync_run is high.
`timescale 1ns/1ps

module bps_fet_model (
    input wire logic i_clock,
    input wire logic i_high_drive,
    input wire logic i_low_drive,
    input wire logic i_slow,
    input wire logic i_enable,
    input wire logic i_sync_run,
    input wire logic [15:0] i_period,
    output logic o_high_off,
    output logic o_low_off,
    output logic o_sync_en
);
    logic [3:0] hi_cnt = 4'h0;
    logic [3:0] lo_cnt = 4'h0;
    logic [15:0] per_cnt = 16'h0;
    logic [3:0] settle;

    ////////////////////////////////////////////////////////////////////////
    // A gate reads off only once its charge has drained below threshold
    assign settle = i_slow ? 4'h6 : 4'h1;
    assign o_high_off = hi_cnt >= settle;
    assign o_low_off = lo_cnt >= settle;
    always @(posedge i_clock) begin
        hi_cnt <= i_high_drive ? 4'h0 : hi_cnt + {3'h0, hi_cnt != 4'hf};
        lo_cnt <= i_low_drive ? 4'h0 : lo_cnt + {3'h0, lo_cnt != 4'hf};
    end

    ////////////////////////////////////////////////////////////////////////
    // Low pulses of 5 clocks, 40 ns, once per period
    always @(posedge i_clock) begin
        if (!i_sync_run || per_cnt >= i_period - 16'h1) begin
            per_cnt <= 16'h0;
        end else begin
            per_cnt <= per_cnt + 16'h1;
        end
    end
    assign o_sync_en = i_enable && !(i_sync_run && per_cnt < 16'h5);

endmodule

/* File: tb/bps_sequencer_tb.sv */
// Purpose: Self-checking bench for the buck PWM sequencer.
// Assumes: Disable filter shortened to 3000 clocks, above the sync limit.
// Notes: Full ramps and hiccup exit take millions of clocks, not run here.
`timescale 1ns/1ps

module bps_sequencer_tb;
    import bps_pkg::*;
    localparam int DIS_N = 3000;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic cken = 1'b1;
    logic bias = 1'b0;
    logic enable = 1'b1;
    logic sync_run = 1'b0;
    logic slow = 1'b0;
    logic oc = 1'b0;
    logic [7:0] demand = 8'hff;
    logic hs, ls, high_off, low_off, sync_en, pump_en, on_pwm;
    logic locked, disabled, hiccup;
    logic [10:0] ramp;
    logic hs_q = 1'b0;
    logic ls_q = 1'b0;
    logic lo_off_q = 1'b0;
    logic hi_off_q = 1'b0;
    int errors = 0;
    int check_count = 0;

    bps_sequencer #(.DISABLE_COUNT(DIS_N)) bps_sequencer_inst (
        .i_clock(clock), .i_srst(srst), .i_clock_en(cken),
        .i_bias_good(bias), .i_sync_en(sync_en), .i_overcurrent(oc),
        .i_high_gate_off(high_off), .i_low_gate_off(low_off),
        .i_duty_demand(demand), .o_high_side_gate_drive(hs),
        .o_low_side_gate_drive(ls), .o_pump_enable(pump_en),
        .o_pump_on_pwm(on_pwm), .o_sync_locked(locked),
        .o_disabled(disabled), .o_hiccup(hiccup), .o_soft_start_ramp(ramp));

    bps_fet_model bps_fet_model_inst (
        .i_clock(clock), .i_high_drive(hs), .i_low_drive(ls), .i_slow(slow),
        .i_enable(enable), .i_sync_run(sync_run), .i_period(16'd800),
        .o_high_off(high_off), .o_low_off(low_off), .o_sync_en(sync_en));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // High-side on-cycles over one free-running period
    task automatic on_count(output int n);
        n = 0;
        repeat (1024) begin
            cyc(1);
            n += int'(hs);
        end
    endtask

    task automatic ramp_to(input int v);
        while (int'(ramp) < v) cyc(1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Interlock watch: each gate rises only after the other sensed off
    always @(negedge clock) begin
        if (hs && !hs_q) check(16'(lo_off_q), 16'h1);
        if (ls && !ls_q) check(16'(hi_off_q), 16'h1);
        if (hs && ls) check(16'h1, 16'h0);
        hs_q <= hs;
        ls_q <= ls;
        lo_off_q <= low_off;
        hi_off_q <= high_off;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check({14'h0, hs, ls}, 16'h0);
        check(16'(pump_en), 16'h1);
        check(16'(on_pwm), 16'h0);
        check({13'h0, locked, disabled, hiccup}, 16'h0);
        check(16'(ramp), 16'h0);
    endtask

    task automatic t_power_good();
        cyc(200);
        check(16'(ramp), 16'h0);
        check({14'h0, hs, ls}, 16'h0);
        check(16'(on_pwm), 16'h0);
        bias = 1'b1;
        cyc(2);
        check(16'(on_pwm), 16'h1);
    endtask

    task automatic t_ramp();
        int n, w0, w1, w2, w4, wd, ws;
        logic [10:0] r;
        ramp_to(1);
        r = ramp;
        n = 0;
        while (ramp === r && n < 2000) begin
            cyc(1);
            n++;
        end
        check(16'(n), 16'd1024);
        on_count(w0);
        check(16'(w0), 16'h0);
        ramp_to(9);
        on_count(w1);
        ramp_to(17);
        on_count(w2);
        ramp_to(33);
        on_count(w4);
        check(16'(w2 > w1), 16'h1);
        check(16'(w4 > w2 && w4 <= 16), 16'h1);
        demand = 8'h01;
        on_count(wd);
        check(16'(wd <= 4), 16'h1);
        demand = 8'hff;
        slow = 1'b1;
        on_count(ws);
        check(16'(ws < w4), 16'h1);
        slow = 1'b0;
    endtask

    // Frozen clock enable: ramp and gates hold although periods go by
    task automatic t_freeze();
        logic [10:0] r;
        logic [1:0] g;
        cken = 1'b0;
        cyc(1);
        r = ramp;
        g = {hs, ls};
        cyc(1100);
        check({5'h0, ramp}, {5'h0, r});
        check({14'h0, hs, ls}, {14'h0, g});
        cken = 1'b1;
    endtask

    task automatic t_overcurrent();
        int n;
        oc = 1'b1;
        cyc(1);
        check(16'(hiccup), 16'h1);
        check(16'(ramp), 16'h0);
        oc = 1'b0;
        n = 0;
        repeat (2100) begin
            cyc(1);
            n += int'(hs | ls);
        end
        check(16'(n), 16'h0);
        check(16'(ramp != 11'h0), 16'h1);
        oc = 1'b1;
        cyc(1);
        oc = 1'b0;
        cyc(1);
        check(16'(hiccup), 16'h1);
    endtask

    task automatic t_disable();
        enable = 1'b0;
        cyc(DIS_N - 3);
        check(16'(disabled), 16'h0);
        cyc(5);
        check(16'(disabled), 16'h1);
        check(16'(pump_en), 16'h0);
        check({13'h0, hs, ls, hiccup}, 16'h0);
        enable = 1'b1;
        cyc(1);
        check(16'(disabled), 16'h0);
        check(16'(pump_en), 16'h1);
        check({5'h0, ramp}, 16'h0);
        check({14'h0, hs, ls}, 16'h0);
    endtask

    task automatic t_sync();
        sync_run = 1'b1;
        cyc(8000);
        check(16'(disabled), 16'h0);
        check(16'(pump_en), 16'h1);
        sync_run = 1'b0;
        bias = 1'b0;
        cyc(2);
        check(16'(on_pwm), 16'h0);
        check({14'h0, hs, ls}, 16'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #4 clock = ~clock;
    end

    // Longest path is about 52k clocks; allow 80k
    initial begin
        #(80000 * 8);
        errors++;
        tally_and_finish();
    end

    initial begin
        cyc(16);
        srst = 1'b0;
        cyc(1);
        t_reset();
        t_power_good();
        t_ramp();
        t_freeze();
        t_overcurrent();
        t_disable();
        t_sync();
        tally_and_finish();
    end

endmodule
